// ===== src/hs_pkg.sv
// package for the high-side switch control block
// assumes a single 25 MHz clock domain
package hs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 25000000;
  localparam int CLK_PER_US      = CLK_HZ / 1000000;
  localparam int OC_FILTER_NS    = 16000;   // nominal overcurrent filter
  localparam int OC_FILTER_CYC   = (OC_FILTER_NS * CLK_PER_US) / 1000;
  localparam int OL_FILTER_NS    = 220000;  // nominal open-load filter
  localparam int OL_FILTER_CYC   = (OL_FILTER_NS / 1000) * CLK_PER_US;

  // ----------------------------------------------------------------
  // source select codes and device modes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_OFF   = 4'h0;
  localparam logic [3:0] SRC_ON    = 4'h1;
  localparam logic [3:0] SRC_TMR1  = 4'h2;
  localparam logic [3:0] SRC_TMR2  = 4'h3;
  localparam logic [3:0] SRC_PWM1  = 4'h4;
  localparam logic [3:0] SRC_PWM4  = 4'h7;
  localparam logic [3:0] SRC_SYNC  = 4'h8;
  localparam logic [1:0] WAKE_SYNC = 2'h2;
  localparam logic [9:0] DUTY_MIN_BAD = 10'h001;

  typedef enum logic [2:0] {
    MODE_NORMAL    = 3'b000,
    MODE_STOP      = 3'b001,
    MODE_SLEEP     = 3'b010,
    MODE_RESTART   = 3'b011,
    MODE_FAILSAFE  = 3'b100
  } dev_mode_t;

  // lowpower: stop or sleep
  function automatic logic is_lowpower(input dev_mode_t m);
    is_lowpower = (m == MODE_STOP) || (m == MODE_SLEEP);
  endfunction

endpackage

// ===== src/hs_gen_if.sv
// carries generator waveforms from the generator bank to the switch logic
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface hs_gen_if;
  logic [1:0] tmr_wave;
  logic [3:0] pwm_wave;
  modport src (output tmr_wave, output pwm_wave);
  modport dst (input tmr_wave, input pwm_wave);
endinterface
`default_nettype wire

// ===== src/hs_wave_gen.sv
// two period/duty timers and four 10-bit pwm generators
// assumes clk at 25 MHz and a synchronised active-low reset
`timescale 1ns/1ps
`default_nettype none
module hs_wave_gen
  import hs_pkg::*;
#(
  parameter int TW = 16
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic [TW-1:0]  tmr_period [2],
  input  wire logic [TW-1:0]  tmr_on     [2],
  input  wire logic [9:0]     pwm_duty   [4],
  input  wire logic [3:0]     pwm_fsel,
  hs_gen_if.src               gen
);
  logic [TW-1:0] tcnt_q [2];
  logic [9:0]    pcnt_q [4];
  logic [1:0]    pdiv_q;

  // ------------------------------------------------------------
  // timers
  // ------------------------------------------------------------
  // R19: period and duty
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_q <= '{default: '0};
      gen.tmr_wave <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tcnt_q[i] >= tmr_period[i]) tcnt_q[i] <= '0;
        else tcnt_q[i] <= tcnt_q[i] + 1'b1;
        gen.tmr_wave[i] <= (tcnt_q[i] < tmr_on[i]);
      end
    end
  end

  // ------------------------------------------------------------
  // pwm generators
  // ------------------------------------------------------------
  // R20: two frequencies
  // R25: oscillator derived
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pdiv_q <= 2'h0;
      pcnt_q <= '{default: '0};
      gen.pwm_wave <= 4'h0;
    end else begin
      pdiv_q <= pdiv_q + 2'h1;
      for (int i = 0; i < 4; i++) begin
        if (pwm_fsel[i] || (pdiv_q == 2'h3)) pcnt_q[i] <= pcnt_q[i] + 10'h1;
        // R22: minimum duty unrealised
        gen.pwm_wave[i] <= (pwm_duty[i] != DUTY_MIN_BAD) &&
                           (pcnt_q[i] < pwm_duty[i]);
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/hs_switch_ctrl.sv
// Contract
// R1: undervoltage turns outputs off unless shutdown disable is set
// R2: config changes only in normal; restart or failsafe disables outputs
// R3: uv end with recovery enabled restores programmed state
// R4: uv end without recovery keeps outputs off and clears config
// R5: uv reported only by undervoltage flag
// R6: overvoltage turns outputs off subject to disable bits
// R7: normal mode per-output ov disable keeps output on
// R8: low-power single ov disable keeps all outputs on
// R9: ov end restores output only if its recovery bit set
// R10: ov end without recovery keeps off and clears config
// R11: ov reported only by overvoltage flag
// R12: overcurrent beyond filter time switches output off
// R13: overcurrent sets sticky flag and forces config to off
// R14: host reactivates by writing on or timer after clearing flag
// R15: sustained low current while on sets open-load flag
// R16: open-load flags sticky until host clears
// R17: each output selects one of nine sources
// R18: static on and off apply in normal, stop and sleep
// R19: two timers with independent period and duty
// R20: four pwm generators, 10-bit duty, two frequencies
// R21: host programs generator first; pwm starts at assignment
// R22: smallest nonzero duty code not realised
// R23: wake function 10 makes fourth wake pin sync, no wake-up
// R24: host sets sync function before selecting sync code
// R25: all times derived from internal oscillator counters
//
// top of the high-side switch control block
// assumes analog comparators deliver asynchronous levels
// assumes config and timing inputs stay steady between write pulses
`timescale 1ns/1ps
`default_nettype none
module hs_switch_ctrl
  import hs_pkg::*;
#(
  parameter int N  = 4,
  parameter int TW = 16,
  parameter int OC_CYC = OC_FILTER_CYC,
  parameter int OL_CYC = OL_FILTER_CYC
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire dev_mode_t         dev_mode,
  input  wire logic              cfg_we,
  input  wire logic [4*N-1:0]    cfg_src,
  input  wire logic              undervoltage_shutdown_disable,
  input  wire logic              undervoltage_recovery_enable,
  input  wire logic [N-1:0]      normal_overvoltage_shutdown_disable,
  input  wire logic              lowpower_overvoltage_shutdown_disable,
  input  wire logic [N-1:0]      overvoltage_recovery_enable,
  input  wire logic [TW-1:0]     tmr_period [2],
  input  wire logic [TW-1:0]     tmr_on     [2],
  input  wire logic [9:0]        pwm_duty   [4],
  input  wire logic [3:0]        pwm_fsel,
  input  wire logic [1:0]        wake_pin_function_select,
  input  wire logic              fourth_wake_pin,
  input  wire logic              supply_uv,
  input  wire logic              supply_ov,
  input  wire logic [N-1:0]      oc_detect,
  input  wire logic [N-1:0]      ol_detect,
  input  wire logic              uv_flag_clr,
  input  wire logic              ov_flag_clr,
  input  wire logic [N-1:0]      oc_flag_clr,
  input  wire logic [N-1:0]      ol_flag_clr,
  output logic [4*N-1:0]         output_source_control,
  output logic [N-1:0]           high_side_output_n,
  output logic                   undervoltage_flag,
  output logic                   overvoltage_flag,
  output logic [N-1:0]           overcurrent_flag,
  output logic [N-1:0]           open_load_flag,
  output logic                   wake4_enable
);
  // --------------------------------------------------------------
  // reset release and input synchronisers
  // --------------------------------------------------------------
  logic [1:0]   rst_sync_q;
  logic         rst_n;
  logic [1:0]   uv_s_q, ov_s_q, wk_s_q;
  logic [N-1:0] oc_s1_q, oc_s2_q, ol_s1_q, ol_s2_q;

  // release internal reset two edges after rstn rises
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // two flops on every analog level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_s_q  <= 2'h0;
      ov_s_q  <= 2'h0;
      wk_s_q  <= 2'h0;
      oc_s1_q <= '0;
      oc_s2_q <= '0;
      ol_s1_q <= '0;
      ol_s2_q <= '0;
    end else begin
      uv_s_q  <= {uv_s_q[0], supply_uv};
      ov_s_q  <= {ov_s_q[0], supply_ov};
      wk_s_q  <= {wk_s_q[0], fourth_wake_pin};
      oc_s1_q <= oc_detect;
      oc_s2_q <= oc_s1_q;
      ol_s1_q <= ol_detect;
      ol_s2_q <= ol_s1_q;
    end
  end

  // --------------------------------------------------------------
  // waveform generators
  // --------------------------------------------------------------
  hs_gen_if gen_if ();

  hs_wave_gen #(.TW(TW)) u_gen (
    .clk        (clk),
    .rst_n      (rst_n),
    .tmr_period (tmr_period),
    .tmr_on     (tmr_on),
    .pwm_duty   (pwm_duty),
    .pwm_fsel   (pwm_fsel),
    .gen        (gen_if)
  );

  // sync source reads low unless the pin is in sync function
  // R23: sync mode blocks wake
  logic sync_mode;
  assign sync_mode    = (wake_pin_function_select == WAKE_SYNC);
  assign wake4_enable = !sync_mode;

  // --------------------------------------------------------------
  // shutdown conditions
  // --------------------------------------------------------------
  logic         lowpower, uv_q, ov_q;
  logic         uv_act;
  logic [N-1:0] ov_act, uv_shut_q, ov_shut_q, oc_trip;
  logic [3:0]   src [N];

  // fault levels below are two flops behind the comparators
  assign lowpower = is_lowpower(dev_mode);
  assign uv_q     = uv_s_q[1];
  assign ov_q     = ov_s_q[1];
  // R1: uv shutdown gate
  assign uv_act   = uv_q && !undervoltage_shutdown_disable;

  // per output overvoltage shutdown request
  always_comb begin
    for (int i = 0; i < N; i++) begin
      // R6: ov shutdown gate
      // R7: per-output normal disable
      // R8: lowpower global disable
      if (lowpower) ov_act[i] = ov_q && !lowpower_overvoltage_shutdown_disable;
      else ov_act[i] = ov_q && !normal_overvoltage_shutdown_disable[i];
    end
  end

  // --------------------------------------------------------------
  // overcurrent and open-load filters
  // --------------------------------------------------------------
  logic [15:0] oc_cnt_q [N];
  logic [15:0] ol_cnt_q [N];
  logic [N-1:0] ol_hit;

  // a count restarts whenever the level drops or the switch is off
  // R12: overcurrent filter
  // R15: open-load filter
  // R25: oscillator counted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_cnt_q <= '{default: '0};
      ol_cnt_q <= '{default: '0};
    end else begin
      for (int i = 0; i < N; i++) begin
        if (oc_s2_q[i] && high_side_output_n[i]) begin
          if (oc_cnt_q[i] != 16'(OC_CYC)) oc_cnt_q[i] <= oc_cnt_q[i] + 16'h1;
        end else oc_cnt_q[i] <= 16'h0;
        if (ol_s2_q[i] && high_side_output_n[i]) begin
          if (ol_cnt_q[i] != 16'(OL_CYC)) ol_cnt_q[i] <= ol_cnt_q[i] + 16'h1;
        end else ol_cnt_q[i] <= 16'h0;
      end
    end
  end

  // counts saturate, so a hit stands while the level lasts and the switch stays on
  always_comb begin
    for (int i = 0; i < N; i++) begin
      oc_trip[i] = oc_s2_q[i] && high_side_output_n[i] &&
                   (oc_cnt_q[i] == 16'(OC_CYC));
      ol_hit[i]  = ol_s2_q[i] && high_side_output_n[i] &&
                   (ol_cnt_q[i] == 16'(OL_CYC));
    end
  end

  // --------------------------------------------------------------
  // source configuration and shutdown latches
  // --------------------------------------------------------------
  // R2: normal-only config writes
  // R13: oc forces config off
  // R4: uv clears config
  // R10: ov clears config
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) src[i] <= SRC_OFF;
      uv_shut_q <= '0;
      ov_shut_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (cfg_we && dev_mode == MODE_NORMAL) src[i] <= cfg_src[4*i +: 4];
        // latch only live sources; the release decides recovery
        if (uv_act && src[i] != SRC_OFF) uv_shut_q[i] <= 1'b1;
        else if (!uv_act && uv_shut_q[i]) begin
          uv_shut_q[i] <= 1'b0;
          // R3: uv recovery restores
          if (!undervoltage_recovery_enable) src[i] <= SRC_OFF;
        end
        if (ov_act[i] && src[i] != SRC_OFF) ov_shut_q[i] <= 1'b1;
        else if (!ov_act[i] && ov_shut_q[i]) begin
          ov_shut_q[i] <= 1'b0;
          // R9: ov recovery restores
          if (!overvoltage_recovery_enable[i]) src[i] <= SRC_OFF;
        end
        // overcurrent last, so it beats a write in the same cycle
        if (oc_trip[i]) src[i] <= SRC_OFF;
      end
    end
  end

  // stored configuration read back, device clears included
  always_comb begin
    for (int i = 0; i < N; i++) output_source_control[4*i +: 4] = src[i];
  end

  // --------------------------------------------------------------
  // output drive
  // --------------------------------------------------------------
  logic [N-1:0] wave;

  // R17: nine source mux
  // R18: static in normal, stop and sleep; restart and failsafe force off
  // R21: pwm at assignment
  // R24: sync follows pin
  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (src[i])
        SRC_OFF:  wave[i] = 1'b0;
        SRC_ON:   wave[i] = 1'b1;
        SRC_TMR1: wave[i] = gen_if.tmr_wave[0];
        SRC_TMR2: wave[i] = gen_if.tmr_wave[1];
        SRC_PWM1, 4'h5, 4'h6, SRC_PWM4:
          wave[i] = gen_if.pwm_wave[src[i][1:0]];
        SRC_SYNC: wave[i] = sync_mode && wk_s_q[1];
        // codes nine and up fall to off
        default:  wave[i] = 1'b0;
      endcase
    end
  end

  // R2: restart and failsafe off
  // live fault terms stop a source written during a fault from
  // pulsing the switch before its shutdown latch is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) high_side_output_n <= '0;
    else if (dev_mode == MODE_RESTART || dev_mode == MODE_FAILSAFE)
      high_side_output_n <= '0;
    else
      high_side_output_n <= wave & ~uv_shut_q & ~ov_shut_q & ~oc_trip &
                            ~{N{uv_act}} & ~ov_act;
  end

  // --------------------------------------------------------------
  // sticky status flags, set wins over clear
  // --------------------------------------------------------------
  // set while a live output is being shut; a clear then loses
  // R5: uv own flag only
  // R11: ov own flag only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      undervoltage_flag <= 1'b0;
      overvoltage_flag  <= 1'b0;
    end else begin
      undervoltage_flag <= (uv_act && |src_on_mask()) ||
                           (undervoltage_flag && !uv_flag_clr);
      overvoltage_flag  <= (|(ov_act & src_on_mask())) ||
                           (overvoltage_flag && !ov_flag_clr);
    end
  end

  // R13: oc sticky flag
  // R16: open-load sticky
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overcurrent_flag <= '0;
      open_load_flag   <= '0;
    end else begin
      overcurrent_flag <= oc_trip | (overcurrent_flag & ~oc_flag_clr);
      open_load_flag   <= ol_hit | (open_load_flag & ~ol_flag_clr);
    end
  end

  // outputs with a source other than off
  // shared by both supply fault flags
  function automatic logic [N-1:0] src_on_mask();
    for (int i = 0; i < N; i++) src_on_mask[i] = (src[i] != SRC_OFF);
  endfunction
endmodule
`default_nettype wire

// ===== dv/hs_load_model.sv
// external loads on the four switch outputs
// assumes drive comes straight from the switch outputs
`timescale 1ns/1ps
`default_nettype none
module hs_load_model (
  input  wire logic [3:0] drive,
  input  wire logic [3:0] short_mask,
  input  wire logic [3:0] open_mask,
  output logic      [3:0] oc_level,
  output logic      [3:0] ol_level
);
  // current, high or missing, flows only while switched on
  assign oc_level = drive & short_mask;
  assign ol_level = drive & open_mask;
endmodule
`default_nettype wire

// ===== dv/hs_chk_asserts.sv
// assertion checker for the high-side switch control top
// assumes it is bound onto the top ports, one clock
`timescale 1ns/1ps
`default_nettype none
module hs_chk
  import hs_pkg::*;
#(parameter int N = 4, parameter int OC_CYC = 8) (
  input wire logic           clk,
  input wire logic           rstn,
  input wire dev_mode_t      dev_mode,
  input wire logic           cfg_we,
  input wire logic           undervoltage_shutdown_disable,
  input wire logic           supply_uv,
  input wire logic           supply_ov,
  input wire logic [N-1:0]   oc_detect,
  input wire logic [N-1:0]   ol_flag_clr,
  input wire logic [4*N-1:0] output_source_control,
  input wire logic [N-1:0]   high_side_output_n,
  input wire logic [N-1:0]   overcurrent_flag,
  input wire logic [N-1:0]   open_load_flag,
  input wire logic [1:0]     wake_pin_function_select,
  input wire logic           wake4_enable
);
  // ----------------
  // helper counters
  // ----------------
  logic [2:0]  q_q;
  logic [15:0] oc_q;
  // fault-free cycles, restart counts as a fault
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      q_q <= 3'h0;
    else if (supply_uv || supply_ov || |oc_detect || dev_mode > MODE_SLEEP)
      q_q <= 3'h0;
    else if (q_q != 3'h7)
      q_q <= q_q + 3'h1;
  end
  // overcurrent cycles on output 0 since it was driven
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      oc_q <= 16'h0000;
    else if (!oc_detect[0])
      oc_q <= 16'h0000;
    else if (oc_q != 16'h0000 || high_side_output_n[0])
      oc_q <= oc_q + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RESTART_OFF: assert property (
    (dev_mode == MODE_RESTART || dev_mode == MODE_FAILSAFE)[*2]
    |-> high_side_output_n == '0) else $error("on in restart");
  AST_CFG_REFUSED: assert property (
    cfg_we && q_q == 3'h7 && (dev_mode == MODE_STOP || dev_mode == MODE_SLEEP)
    |=> $stable(output_source_control)) else $error("config taken");
  AST_STATIC_ON: assert property (
    (output_source_control[3:0] == SRC_ON && q_q == 3'h7)[*2]
    |-> high_side_output_n[0]) else $error("static on lost");
  AST_STATIC_OFF: assert property (
    (output_source_control[3:0] == SRC_OFF)[*2]
    |-> !high_side_output_n[0]) else $error("static off lost");
  AST_UV_SHUT: assert property (
    (supply_uv && !undervoltage_shutdown_disable)[*5]
    |-> high_side_output_n == '0) else $error("uv not shut");
  AST_OC_EARLY: assert property (
    oc_q == OC_CYC - 1 |-> high_side_output_n[0]) else $error("oc early");
  AST_OC_TRIP: assert property (
    $rose(overcurrent_flag[0]) |-> ##[0:2] (!high_side_output_n[0]
    && output_source_control[3:0] == SRC_OFF)) else $error("oc trip");
  AST_OL_STICKY: assert property (
    open_load_flag[0] && !ol_flag_clr[0] |=> open_load_flag[0])
    else $error("ol flag lost");
  AST_SYNC_WAKE: assert property (
    wake4_enable == (wake_pin_function_select != WAKE_SYNC))
    else $error("wake enable wrong");
  cover property (q_q == 3'h7 && high_side_output_n[0]);
  cover property ($rose(overcurrent_flag[0]));
  cover property ($rose(open_load_flag[0]));
endmodule
bind hs_switch_ctrl hs_chk #(.N(N), .OC_CYC(OC_CYC)) u_chk (.*);
`default_nettype wire

// ===== dv/high_side_switch_control_tb_top.sv
// testbench for the high-side switch control block
// assumes short filter counts and the load model
`timescale 1ns/1ps
`default_nettype none
module high_side_switch_control_tb_top
  import hs_pkg::*;
;
  localparam int OCC = 8;
  localparam int OLC = 20;
  localparam int WIN [8] = '{40, 40, 40, 40, 4096, 4096, 4096, 4096};
  localparam int EON [8] = '{0, 40, 12, 8, 256, 512, 768, 0};
  localparam int ERS [8] = '{0, 0, 4, 8, 4, 4, 1, 0};
  logic        clk, rstn, we, uvd, uvr, lpd, wp, uv, ov, uvc, ovc;
  logic        uf, of, w4e;
  dev_mode_t   md;
  logic [15:0] src, cs;
  logic [3:0]  nod, ovr, fs, oc, ol, occ, olc, hs, ocf, olf, sh, op;
  logic [1:0]  ws;
  logic [15:0] tp [2];
  logic [15:0] tn [2];
  logic [9:0]  pd [4];
  int          fails = 0;
  int          checks_done = 0;
  logic [15:0] on, rs;
  hs_switch_ctrl #(.OC_CYC(OCC), .OL_CYC(OLC)) u_dut (
    .clk(clk), .rstn(rstn), .dev_mode(md), .cfg_we(we), .cfg_src(src),
    .undervoltage_shutdown_disable(uvd),
    .undervoltage_recovery_enable(uvr),
    .normal_overvoltage_shutdown_disable(nod),
    .lowpower_overvoltage_shutdown_disable(lpd),
    .overvoltage_recovery_enable(ovr), .tmr_period(tp), .tmr_on(tn),
    .pwm_duty(pd), .pwm_fsel(fs), .wake_pin_function_select(ws),
    .fourth_wake_pin(wp), .supply_uv(uv), .supply_ov(ov),
    .oc_detect(oc), .ol_detect(ol), .uv_flag_clr(uvc),
    .ov_flag_clr(ovc), .oc_flag_clr(occ), .ol_flag_clr(olc),
    .output_source_control(cs), .high_side_output_n(hs),
    .undervoltage_flag(uf), .overvoltage_flag(of),
    .overcurrent_flag(ocf), .open_load_flag(olf), .wake4_enable(w4e));
  hs_load_model u_load (.drive(hs), .short_mask(sh), .open_mask(op),
    .oc_level(oc), .ol_level(ol));
  // ----------------
  // access tasks
  // ----------------
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [15:0] v);
    src = v;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(2);
  endtask
  task automatic fault(input logic u, input logic o);
    uv = u;
    ov = o;
    cyc(6);
  endtask
  task automatic clr();
    {uvc, ovc, occ, olc} = '1;
    cyc(1);
    {uvc, ovc, occ, olc} = '0;
    cyc(1);
  endtask
  // on cycles and rising edges of output 0 over whole periods
  task automatic meas(input int n);
    logic p;
    p = hs[0];
    on = 16'h0000;
    rs = 16'h0000;
    repeat (n) begin
      cyc(1);
      on += {15'h0000, hs[0]};
      rs += {15'h0000, hs[0] & ~p};
      p = hs[0];
    end
  endtask
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    {rstn, we, uvd, uvr, lpd, wp, uv, ov, uvc, ovc} = '0;
    {src, nod, ovr, occ, olc, sh, op, ws} = '0;
    md = MODE_NORMAL;
    fs = 4'hB;
    tp = '{16'h0009, 16'h0004};
    tn = '{16'h0003, 16'h0001};
    pd = '{10'h040, 10'h080, 10'h0C0, 10'h001};
    cyc(4);
    rstn = 1'b1;
    cyc(3);
    chk("reset out", 16'h0000, hs);
    chk("reset flags", 16'h0000, {olf, ocf, of, uf});
    chk("wake en", 16'h0001, w4e);
    // sweep every non-sync source on output 0
    for (int c = 0; c < 8; c++) begin
      wr({12'h000, c[3:0]});
      cyc(4);
      meas(WIN[c]);
      chk("on cycles", EON[c][15:0], on[15:0]);
      chk("rises", ERS[c][15:0], rs[15:0]);
    end
    ws = WAKE_SYNC;
    wr({12'h000, SRC_SYNC});
    chk("wake off", 16'h0000, w4e);
    wp = 1'b1;
    cyc(5);
    chk("sync high", 16'h0001, hs);
    wp = 1'b0;
    cyc(5);
    chk("sync low", 16'h0000, hs);
    wr(16'h0011);
    for (int m = 1; m < 3; m++) begin
      md = dev_mode_t'(m[2:0]);
      wr(16'h0000);
      chk("cfg held", 16'h0011, cs);
      chk("low power on", 16'h0003, hs);
    end
    for (int m = 3; m < 5; m++) begin
      md = dev_mode_t'(m[2:0]);
      cyc(3);
      chk("restart off", 16'h0000, hs);
      md = MODE_NORMAL;
      cyc(3);
      chk("cfg kept", 16'h0003, hs);
    end
    md = MODE_NORMAL;
    uvr = 1'b1;
    wr(16'h0001);
    fault(1'b1, 1'b0);
    chk("uv off", 16'h0000, hs);
    chk("uv flags", 16'h0001, {olf, ocf, of, uf});
    fault(1'b0, 1'b0);
    chk("uv back", 16'h0001, hs);
    uvr = 1'b0;
    fault(1'b1, 1'b0);
    fault(1'b0, 1'b0);
    chk("uv cfg", 16'h0000, cs);
    chk("uv stay", 16'h0000, hs);
    clr();
    uvd = 1'b1;
    wr(16'h0001);
    fault(1'b1, 1'b0);
    chk("uv kept", 16'h0001, hs);
    fault(1'b0, 1'b0);
    uvd = 1'b0;
    nod = 4'h2;
    ovr = 4'h1;
    wr(16'h0011);
    fault(1'b0, 1'b1);
    chk("ov keep", 16'h0002, hs);
    chk("ov flags", 16'h0002, {olf, ocf, of, uf});
    fault(1'b0, 1'b0);
    chk("ov back", 16'h0003, hs);
    ovr = 4'h0;
    fault(1'b0, 1'b1);
    fault(1'b0, 1'b0);
    chk("ov cfg", 16'h0010, cs);
    nod = 4'h0;
    ovr = 4'hF;
    lpd = 1'b1;
    wr(16'h0011);
    md = MODE_STOP;
    fault(1'b0, 1'b1);
    chk("lp keep", 16'h0003, hs);
    fault(1'b0, 1'b0);
    lpd = 1'b0;
    fault(1'b0, 1'b1);
    chk("lp off", 16'h0000, hs);
    fault(1'b0, 1'b0);
    chk("lp back", 16'h0003, hs);
    md = MODE_NORMAL;
    clr();
    sh = 4'h1;
    wr(16'h0001);
    cyc(OCC - 3);
    chk("oc early", 16'h0001, hs);
    cyc(10);
    chk("oc trip", 16'h0000, hs);
    chk("oc cfg", 16'h0000, cs);
    chk("oc flag", 16'h0001, ocf);
    sh = 4'h0;
    clr();
    wr(16'h0001);
    chk("oc again", 16'h0001, hs);
    chk("oc clear", 16'h0000, ocf);
    op = 4'h1;
    cyc(OLC + 8);
    chk("ol flag", 16'h0001, olf);
    chk("ol on", 16'h0001, hs);
    op = 4'h0;
    cyc(4);
    chk("ol sticky", 16'h0001, olf);
    clr();
    chk("ol clear", 16'h0000, olf);
    give_verdict();
  end
endmodule
`default_nettype wire
